// File: logic/sbw_write_port.sv
// top of the lane-masked write port
`timescale 1ns/1ps
`include "sbw_defines.svh"
// What this block does
// - x8: selects 0,1 gate nibbles 3:0, 7:4
// - x18: selects 0,1 gate bytes 8:0, 17:9
// - x9: one select gates all bits 8:0
// - x36: selects 0..3 gate four 9-bit lanes
// - x36 all selects low writes bits 35:0
// - all selects high leaves location unchanged
// - selects sampled per beat, may change
// - data and selects taken on both edges
// - request right after accepted one ignored
module sbw_write_port #(
  parameter int W = `SBW_DATA_W,
  parameter int AW = `SBW_ADDR_W,
  parameter int DEPTH = `SBW_FIFO_DEPTH,
  parameter int L = sbw_pkg::lanes_of(W)
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // write request
  input wire logic write_port_select_n,
  input wire logic [AW-3:0] wr_addr,
  output logic write_port_ready,
  // beat on the k rise
  input wire logic [W-1:0] wr_data_k,
  input wire logic [L-1:0] lane_write_select_n_k,
  // beat on the k-bar rise
  input wire logic [W-1:0] wr_data_kb,
  input wire logic [L-1:0] lane_write_select_n_kb,
  // array side
  input wire logic array_hold,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  localparam int CW = $clog2(DEPTH + 1);

  // only the four documented organisations are served
  if (L == 0)
    $error("sbw_write_port width must be 8, 9, 18 or 36");
  // at least two bursts of four beats must be addressable
  if (AW < 3)
    $error("sbw_write_port address width too small");
  // two pairs plus up to two owed must fit
  if (DEPTH < `SBW_PAIR_BEATS + 2)
    $error("sbw_write_port fifo too shallow");

  // whole state of this module
  sbw_pkg::sbw_top_s st_r, st_nxt;

  // carriers: capture to buffer, buffer to array
  sbw_beat_if #(.W(W), .AW(AW), .L(L)) cap_if ();
  sbw_beat_if #(.W(W), .AW(AW), .L(L)) arr_if ();

  logic [CW-1:0] lvl; // buffer occupancy
  logic [1:0] owed; // pairs of the running burst still to push, this edge included
  logic room; // space for a whole burst
  logic accept; // request taken this cycle
  logic push; // pair handed to the buffer
  logic [AW-1:0] beat_addr; // address of the k beat of the pair

  // pairs still owed: two while the first pair goes, one while the second goes;
  // counting none for the second pair let a gapless burst overrun a nearly full buffer
  assign owed = (st_r.phase == sbw_pkg::SBW_PAIR0) ? 2'h2
              : (st_r.phase == sbw_pkg::SBW_PAIR1) ? 2'h1 : 2'h0;

  // room for both pairs, counting what is already owed;
  // conservative, a pop in the same cycle is not credited
  assign room = int'(lvl) + int'(owed) + `SBW_PAIR_BEATS <= DEPTH;

  // back-pressure seen by the controller
  assign write_port_ready = room;

  // a request in the cycle after an accepted one is dropped,
  // so a stray request never restarts a burst mid-flight
  assign accept = ce && !write_port_select_n && room
                  && st_r.phase != sbw_pkg::SBW_PAIR0;

  // burst sequencer
  always_comb
  begin
    st_nxt = st_r;
    case (st_r.phase)
      // waiting for a request
      sbw_pkg::SBW_IDLE:
      begin
        if (accept)
        begin
          st_nxt.phase = sbw_pkg::SBW_PAIR0;
          st_nxt.base = 32'(wr_addr);
        end
      end
      // beats A and A+1 arrive now
      sbw_pkg::SBW_PAIR0:
      begin
        st_nxt.phase = sbw_pkg::SBW_PAIR1;
      end
      // beats A+2 and A+3 arrive now; a new burst may start
      sbw_pkg::SBW_PAIR1:
      begin
        if (accept)
        begin
          st_nxt.phase = sbw_pkg::SBW_PAIR0;
          st_nxt.base = 32'(wr_addr);
        end
        else
        begin
          st_nxt.phase = sbw_pkg::SBW_IDLE;
        end
      end
      // unreachable encoding falls back to idle
      default:
      begin
        st_nxt.phase = sbw_pkg::SBW_IDLE;
      end
    endcase
  end

  // state register, frozen while ce is low
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  // first beat of each pair: A for the first, A+2 for the second
  always_comb
  begin
    beat_addr = {st_r.base[AW-3:0], 2'b00};
    if (st_r.phase == sbw_pkg::SBW_PAIR1)
      beat_addr = {st_r.base[AW-3:0], 2'b10};
  end

  // data beats are pushed only inside an accepted burst,
  // so selects outside one have no effect
  assign push = ce && cap_if.valid && cap_if.ready;
  assign cap_if.valid = st_r.phase != sbw_pkg::SBW_IDLE;
  assign cap_if.addr = beat_addr;

  // both beats of the cycle travel with their own selects;
  // the buffer registers them at this edge
  assign cap_if.d_k = wr_data_k;
  assign cap_if.m_k = lane_write_select_n_k;
  assign cap_if.d_kb = wr_data_kb;
  assign cap_if.m_kb = lane_write_select_n_kb;

  // beat-pair buffer between capture and array
  sbw_fifo #(
    .W(W),
    .AW(AW),
    .L(L),
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .inp(cap_if.snk),
    .outp(arr_if.src),
    .level(lvl)
  );

  // array with per-lane write enables
  sbw_lane_array #(
    .W(W),
    .AW(AW),
    .L(L)
  ) u_array (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .inp(arr_if.snk),
    .hold(array_hold),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // checks on sequencing
  default clocking cb @(posedge ref_clk iff ce);
  endclocking
  default disable iff (!arst_n);

  // two pairs follow every accepted request
  sequence s_two_pairs;
    push ##1 push;
  endsequence

  // second pair sits two beats above the first
  sequence s_addr_step;
    push ##1 (push && cap_if.addr == $past(cap_if.addr) + AW'(2));
  endsequence

  property p_burst;
    accept |=> s_two_pairs;
  endproperty

  property p_step;
    accept |=> s_addr_step;
  endproperty

  // named pieces of the longer checks: a stray request mid-burst
  sequence s_busy_req;
    st_r.phase == sbw_pkg::SBW_PAIR0 && !write_port_select_n;
  endsequence

  // a new burst asked for in the last data cycle of the old one
  sequence s_gapless;
    st_r.phase == sbw_pkg::SBW_PAIR1 && accept;
  endsequence

  // last data cycle with nothing new taken
  sequence s_wind_down;
    st_r.phase == sbw_pkg::SBW_PAIR1 && !accept;
  endsequence

  // the stray request neither restarts the burst nor moves its base
  property p_busy_drop;
    s_busy_req |=> st_r.phase == sbw_pkg::SBW_PAIR1 && $stable(st_r.base);
  endproperty

  // gapless bursts still get both of their pairs;
  // this is the case that leans hardest on the room check
  property p_gapless;
    s_gapless |=> s_two_pairs;
  endproperty

  // after the last pair the capture side goes quiet
  property p_wind_down;
    s_wind_down |=> st_r.phase == sbw_pkg::SBW_IDLE && !cap_if.valid;
  endproperty

  // the buffered entry is exactly what stood on the pins at the push;
  // looks into the buffer, since the pins alone cannot show it
  property p_entry;
    push |=> u_fifo.mem[$past(u_fifo.st_r.wp)]
             == $past({cap_if.addr, wr_data_k, lane_write_select_n_k, wr_data_kb, lane_write_select_n_kb});
  endproperty

  // the k-bar selects sit in the low end of the entry
  property p_kb_sel;
    push |=> u_fifo.mem[$past(u_fifo.st_r.wp)][L-1:0] == $past(lane_write_select_n_kb);
  endproperty

  // without room no burst may start
  property p_no_room;
    !write_port_ready |=> st_r.phase != sbw_pkg::SBW_PAIR0;
  endproperty

  ign_second_a: assert property (accept |=> !accept)
    else $error("back-to-back request accepted");
  burst_pairs_a: assert property (p_burst)
    else $error("burst did not push two pairs");
  addr_step_a: assert property (p_step)
    else $error("second pair address wrong");
  no_room_a: assert property (p_no_room)
    else $error("request taken without room");
  sel_pass_a: assert property (p_kb_sel)
    else $error("k-bar selects not carried");
  push_room_a: assert property (cap_if.valid |-> cap_if.ready)
    else $error("pair pushed into full buffer");

  // checks on stray requests, gapless bursts and the buffer
  // a request mid-burst is dropped
  busy_drop_a: assert property (p_busy_drop)
    else $error("request during a burst restarted it");
  // a burst may follow with no gap
  gapless_a: assert property (p_gapless)
    else $error("gapless burst lost a pair");
  // each burst is two pairs and no more
  wind_down_a: assert property (p_wind_down)
    else $error("capture stayed busy after a burst");
  // both beats and their selects are kept as sampled
  entry_kept_a: assert property (p_entry)
    else $error("buffered pair differs from the pins");
  // the first pair lands on the burst address
  first_addr_a: assert property (accept |=> cap_if.addr == {$past(wr_addr), 2'h0})
    else $error("first pair address wrong");
  // the first pair is always followed by the second
  pair1_next_a: assert property (st_r.phase == sbw_pkg::SBW_PAIR0 |=> st_r.phase == sbw_pkg::SBW_PAIR1)
    else $error("second pair skipped");
  // the base stays put while the burst runs
  addr_hold_a: assert property (st_r.phase == sbw_pkg::SBW_PAIR0 |=> $stable(st_r.base))
    else $error("burst base moved mid-burst");
  // no request, no burst
  no_req_a: assert property (write_port_select_n |=> st_r.phase != sbw_pkg::SBW_PAIR0)
    else $error("burst started without a request");
  // an empty idle port always takes a burst
  ready_idle_a: assert property (st_r.phase == sbw_pkg::SBW_IDLE && lvl == '0 |-> write_port_ready)
    else $error("empty port refused a burst");
  // the count never passes the depth
  level_cap_a: assert property (lvl <= CW'(DEPTH))
    else $error("buffer count past its depth");
  // a held drain never loses entries
  hold_stall_a: assert property (array_hold |=> lvl >= $past(lvl))
    else $error("buffer drained while held");
endmodule

// File: logic/sbw_defines.svh
// shared constants of the lane-masked write path
`ifndef SBW_DEFINES_SVH
`define SBW_DEFINES_SVH
// beats in one write burst
`define SBW_BEATS 4
// beats carried in one cycle, k rise then k-bar rise
`define SBW_PAIR_BEATS 2
// beat-pair buffer depth
`define SBW_FIFO_DEPTH 32
// default organisation width
`define SBW_DATA_W 36
// default array address width, in beats
`define SBW_ADDR_W 8
`endif

// File: logic/sbw_pkg.sv
// types of the lane-masked write path
package sbw_pkg;
  // burst phase of the write port
  typedef enum logic [1:0] {
    SBW_IDLE,
    SBW_PAIR0,
    SBW_PAIR1
  } sbw_phase_e;
  // whole state of the top module
  typedef struct packed {
    sbw_phase_e phase;
    logic [31:0] base;
  } sbw_top_s;
  // lane count for an organisation, 0 if unsupported
  function automatic int lanes_of(input int w);
    int n;
    n = 0;
    if (w == 8 || w == 18)
      n = 2;
    else if (w == 9)
      n = 1;
    else if (w == 36)
      n = 4;
    return n;
  endfunction
endpackage

// File: logic/sbw_beat_if.sv
// beat-pair carrier, capture to buffer and buffer to array
`timescale 1ns/1ps
interface sbw_beat_if #(
  parameter int W = 36,
  parameter int AW = 8,
  parameter int L = 4
);
  logic valid; // pair present
  logic ready; // sink takes it
  logic [AW-1:0] addr; // address of k beat
  logic [W-1:0] d_k; // k-rise data
  logic [L-1:0] m_k; // k-rise lane selects, low writes
  logic [W-1:0] d_kb; // k-bar-rise data
  logic [L-1:0] m_kb; // k-bar-rise lane selects
  modport src (output valid, addr, d_k, m_k, d_kb, m_kb, input ready);
  modport snk (input valid, addr, d_k, m_k, d_kb, m_kb, output ready);
endinterface

// File: logic/sbw_fifo.sv
// beat-pair fifo with width and depth parameters
`timescale 1ns/1ps
module sbw_fifo #(
  parameter int W = 36,
  parameter int AW = 8,
  parameter int L = 4,
  parameter int DEPTH = 32,
  parameter int CW = $clog2(DEPTH + 1)
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // fill and drain sides
  sbw_beat_if.snk inp,
  sbw_beat_if.src outp,
  // occupancy
  output logic [CW-1:0] level
);
  localparam int EW = AW + 2 * W + 2 * L;
  localparam int PW = $clog2(DEPTH);
  // pointers must wrap on their own
  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
    $error("sbw_fifo depth must be a power of two, at least 4");
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } sbw_fifo_s;
  sbw_fifo_s st_r, st_nxt;
  logic [EW-1:0] mem [DEPTH]; // entry storage
  logic push, pop;
  // honest full and empty
  assign inp.ready = st_r.cnt != CW'(DEPTH);
  assign outp.valid = st_r.cnt != '0;
  assign push = ce && inp.valid && inp.ready;
  assign pop = ce && outp.valid && outp.ready;
  assign level = st_r.cnt;
  assign {outp.addr, outp.d_k, outp.m_k, outp.d_kb, outp.m_kb} = mem[st_r.rp];
  // pointer and count update
  always_comb
  begin
    st_nxt = st_r;
    if (push)
      st_nxt.wp = st_r.wp + PW'(1);
    if (pop)
      st_nxt.rp = st_r.rp + PW'(1);
    st_nxt.cnt = st_r.cnt + CW'(push) - CW'(pop);
  end
  // state register, frozen while ce is low
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end
  // entry write, no reset needed on storage
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[st_r.wp] <= {inp.addr, inp.d_k, inp.m_k, inp.d_kb, inp.m_kb};
  end
endmodule

// File: logic/sbw_lane_array.sv
// storage array applying per-lane write masks
`timescale 1ns/1ps
module sbw_lane_array #(
  parameter int W = 36,
  parameter int AW = 8,
  parameter int L = 4
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // beat pairs from the buffer
  sbw_beat_if.snk inp,
  input wire logic hold,
  // read-back port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  localparam int LW = W / L; // bits per lane
  typedef struct packed {
    logic [W-1:0] rd_data;
  } sbw_arr_s;
  sbw_arr_s st_r, st_nxt;
  logic [W-1:0] mem [2**AW];
  logic [W-1:0] bm_k, bm_kb, old0, old1, mrg0, mrg1;
  logic [AW-1:0] a0, a1;
  logic wr;
  // hold stalls the drain, so the buffer can really fill
  assign inp.ready = !hold;
  assign wr = ce && inp.valid && !hold;
  assign a0 = inp.addr;
  assign a1 = inp.addr + AW'(1);
  assign old0 = mem[a0];
  assign old1 = mem[a1];
  // lane select to bit enable; lane width follows the organisation
  for (genvar b = 0; b < W; b++)
  begin : g_bit
    assign bm_k[b] = ~inp.m_k[b / LW];
    assign bm_kb[b] = ~inp.m_kb[b / LW];
  end
  // deselected lanes keep what is stored
  assign mrg0 = (old0 & ~bm_k) | (inp.d_k & bm_k);
  assign mrg1 = (old1 & ~bm_kb) | (inp.d_kb & bm_kb);
  // both beats of the pair land in one edge
  always_ff @(posedge ref_clk)
  begin
    if (wr)
    begin
      mem[a0] <= mrg0;
      mem[a1] <= mrg1;
    end
  end
  // read data, old contents if written in the same edge
  always_comb
  begin
    st_nxt = st_r;
    if (rd_en)
      st_nxt.rd_data = mem[rd_addr];
  end
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end
  assign rd_data = st_r.rd_data;
  // checks on the merge
  default clocking cb @(posedge ref_clk iff ce);
  endclocking
  default disable iff (!arst_n);
  logic [LW-1:0] old0_lo, d0_lo;
  assign old0_lo = old0[LW-1:0];
  assign d0_lo = inp.d_k[LW-1:0];
  lane_kept_a: assert property (wr && inp.m_k[0] |=> mem[$past(a0)][LW-1:0] == $past(old0_lo))
    else $error("deselected lane changed");
  lane_taken_a: assert property (wr && !inp.m_k[0] |=> mem[$past(a0)][LW-1:0] == $past(d0_lo))
    else $error("selected lane not written");
  whole_word_a: assert property (wr && inp.m_k == '0 |=> mem[$past(a0)] == $past(inp.d_k))
    else $error("full word not written");
  none_written_a: assert property (wr && (&inp.m_kb) |=> mem[$past(a1)] == $past(old1))
    else $error("masked beat altered array");
endmodule

// File: sim/sbw_ctrl_model.sv
// controller model that drives write bursts into the port
`timescale 1ns/1ps
module sbw_ctrl_model (
  // clock and flow control
  input wire logic ref_clk,
  input wire logic ready,
  // request and beats
  output logic sel_n,
  output logic [5:0] addr,
  output logic [35:0] dk,
  output logic [35:0] dkb,
  output logic [3:0] mk,
  output logic [3:0] mkb
);
  // idle values at time zero
  initial
  begin
    sel_n = 1'b1;
    addr = 6'h00;
    {dk, dkb, mk, mkb} = '0;
  end
  // one burst on falling edges; dbl repeats the request at once
  task automatic burst(input logic [5:0] a, input logic [143:0] d, input logic [15:0] m,
    input bit dbl, output bit ok);
    int n;
    n = 0;
    @(negedge ref_clk);
    // wait for room, bounded
    while (ready !== 1'b1 && n < 64)
    begin
      n++;
      @(negedge ref_clk);
    end
    ok = (n < 64);
    sel_n = 1'b0;
    addr = a;
    @(negedge ref_clk);
    sel_n = !dbl; // forbidden repeat only when asked
    addr = a ^ 6'h01;
    {dkb, dk} = d[71:0]; // beats A and A+1 on both edges
    {mkb, mk} = m[7:0];
    @(negedge ref_clk);
    sel_n = 1'b1;
    {dkb, dk} = d[143:72]; // selects may differ per beat
    {mkb, mk} = m[15:8];
    @(negedge ref_clk);
    // stale beats vanish; selects all low so a wrong capture shows
    {dkb, dk} = ~{dkb, dk};
    {mkb, mk} = 8'h00;
  endtask
  // two bursts with no gap: the second is asked for in the first's last data cycle;
  // the caller makes sure that there is room for both
  task automatic chain(input logic [5:0] a, input logic [5:0] b, input logic [287:0] d,
    input logic [31:0] m);
    @(negedge ref_clk);
    sel_n = 1'b0;
    addr = a;
    @(negedge ref_clk);
    sel_n = 1'b1;
    {dkb, dk} = d[71:0];
    {mkb, mk} = m[7:0];
    @(negedge ref_clk);
    sel_n = 1'b0; // next request while the second pair goes
    addr = b;
    {dkb, dk} = d[143:72];
    {mkb, mk} = m[15:8];
    @(negedge ref_clk);
    sel_n = 1'b1;
    {dkb, dk} = d[215:144]; // selects may differ per beat
    {mkb, mk} = m[23:16];
    @(negedge ref_clk);
    {dkb, dk} = d[287:216];
    {mkb, mk} = m[31:24];
    @(negedge ref_clk);
    {dkb, dk} = ~{dkb, dk};
    {mkb, mk} = 8'h00;
  endtask
endmodule

// File: sim/sbw_write_port_bench.sv
// self-checking bench of the lane-masked write port
`timescale 1ns/1ps
module sbw_write_port_bench;
  logic ref_clk, arst_n, ce, hold, rd_en, sel_n, ready;
  logic [7:0] rd_addr;
  logic [5:0] addr;
  logic [35:0] dk, dkb, rd_data;
  logic [3:0] mk, mkb;
  bit ok;
  logic [35:0] sh [256]; // expected array contents
  bit vld [256]; // locations written so far
  int err_total, checks, cyc;
  // rows: burst address and sixteen selects, beat 0 in the low nibble
  logic [5:0] row_a [6] = '{6'h05, 6'h05, 6'h05, 6'h05, 6'h05, 6'h09};
  logic [15:0] row_m [6] = '{16'h0000, 16'h7BDE, 16'hFFFF, 16'hEDB7, 16'h5A0F, 16'h0000};
  // design, full 36-bit organisation, ce driven by the bench
  sbw_write_port dut (.ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .write_port_select_n(sel_n),
    .wr_addr(addr), .write_port_ready(ready), .wr_data_k(dk), .lane_write_select_n_k(mk),
    .wr_data_kb(dkb), .lane_write_select_n_kb(mkb), .array_hold(hold), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data));
  // far-side controller
  sbw_ctrl_model p (.ref_clk(ref_clk), .ready(ready), .sel_n(sel_n), .addr(addr), .dk(dk),
    .dkb(dkb), .mk(mk), .mkb(mkb));
  // data compare
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // flag compare
  task automatic chk1(input logic g, input logic e);
    chk({35'h0, g}, {35'h0, e});
  endtask
  // four distinct beats of one burst
  function automatic logic [143:0] beats(input int s);
    logic [143:0] d;
    for (int i = 0; i < 4; i++)
      d[36*i +: 36] = {8'(s), 4'(i), 24'(s * 66051 + i)};
    return d;
  endfunction
  // shadow updated lane by lane for one burst
  task automatic shadow(input logic [5:0] a, input logic [143:0] d, input logic [15:0] m);
    logic [7:0] b;
    for (int i = 0; i < 16; i++)
    begin
      b = {a, 2'(i / 4)};
      if (!m[i])
        sh[b][9*(i%4) +: 9] = d[36*(i/4) + 9*(i%4) +: 9]; // lane of its own beat
      vld[b] = 1'b1;
    end
  endtask
  // one burst with distinct beat data
  task automatic put(input logic [5:0] a, input logic [15:0] m, input int s, input bit dbl);
    logic [143:0] d;
    d = beats(s);
    p.burst(a, d, m, dbl, ok);
    chk1(ok, 1'b1);
    shadow(a, d, m);
  endtask
  // two gapless bursts on locations already written in full
  task automatic put2(input logic [5:0] a, input logic [5:0] b, input logic [31:0] m, input int s);
    logic [143:0] d, e;
    d = beats(s);
    e = beats(s + 1);
    chk1(ready, 1'b1);
    p.chain(a, b, {e, d}, m);
    shadow(a, d, m[15:0]);
    shadow(b, e, m[31:16]);
  endtask
  // read back every written location after writes settle
  task automatic sweep();
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < 256; i++)
      if (vld[i])
      begin
        rd_en = 1'b1;
        rd_addr = 8'(i);
        @(negedge ref_clk);
        rd_en = 1'b0;
        chk(rd_data, sh[i]);
      end
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // 40 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // hang guard, far above the expected run
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end
  // main sequence
  initial
  begin
    arst_n = 1'b0;
    ce = 1'b1;
    hold = 1'b0;
    rd_en = 1'b0;
    rd_addr = 8'h00;
    repeat (20) @(negedge ref_clk);
    chk1(ready, 1'b1);
    arst_n = 1'b1;
    put(6'h04, 16'h0000, 3, 0);
    for (int r = 0; r < 6; r++)
      put(row_a[r], row_m[r], 16 * r + 5, 0);
    sweep();
    // a request at the edge after an accept must be dropped
    put(6'h05, 16'h0000, 200, 1);
    sweep();
    // second burst asked for in the first's last data cycle, masks changing per beat
    put2(6'h04, 6'h05, 32'h3C96_A50F, 300);
    sweep();
    // stall the drain until the buffer refuses
    hold = 1'b1;
    for (int k = 0; k < 20 && ready === 1'b1; k++)
      put(6'h10 + 6'(k), 16'h0000, 4 * k + 100, 0);
    chk1(ready, 1'b0);
    hold = 1'b0;
    repeat (40) @(negedge ref_clk);
    chk1(ready, 1'b1);
    sweep();
    // a frozen block keeps its read word though a new read is asked for
    rd_en = 1'b1;
    rd_addr = 8'h10;
    @(negedge ref_clk);
    ce = 1'b0;
    rd_addr = 8'h14;
    @(negedge ref_clk);
    chk(rd_data, sh[8'h10]);
    ce = 1'b1;
    @(negedge ref_clk);
    rd_en = 1'b0;
    chk(rd_data, sh[8'h14]);
    close_out();
  end
endmodule
